// File: src/sma_abort_timing.v
// Host bus abort, failure mode gating and command timing supervisor.
`timescale 1ns/1ps
`default_nettype none
`include "sma_consts.vh"
// Summary of operation
// R01: An aborted LPC cycle changes no internal state at all.
// R02: LPC abort withholds SYNC or discards writes; synced reads return all ones.
// R03: SPI read abort drives MISO high until chip select goes inactive.
// R04: SPI write abort drives MISO high and drops all later data bytes.
// R05: The SPI cycle may be stalled with a wait state while decoding.
// R06: In failure mode hash begin, data and end writes complete as dropped writes.
// R07: In failure mode hash commands start nothing and change no state.
// R08: In failure mode FIFO registers and locality changes keep working.
// R09: In failure mode buffer interface registers and locality changes keep working.
// R10: Command time runs from the execute write until completion is signalled.
// R11: FIFO completion sets response available and status valid flags.
// R12: Buffer interface completion clears the start bit to zero.
// R13: Short commands aim for 20 ms and must end within 750 ms.
// R14: Long commands 750 ms, limit 2000 ms; full self-test 1000 ms, limit 2000 ms.
// R15: Signature checks with 3072-bit keys are exempt from the limits.
// R16: Time spent on algorithm self-test is not counted.
// R17: Nonvolatile read limits apply only before the operating system runs.
// R18: Interface timeout A defaults to 750 ms, B to 2000 ms.
// R19: Exactly four interface timeouts; C defaults to 200 ms, D to 30 ms.
// R20: The host waits at most timeout B for a cancellation.
// R21: After shutdown every host access aborts until the next reset; execCmdWr and crbStartWr still start commands.
// R22: The platform reset pin rising edge reinitialises the block.
// R23: Millisecond timing comes from a prescaled counter on the core clock.
module sma_abort_timing #(
   parameter integer MS_CYCLES = `SMA_MS_CYCLES
) (
   input  wire        core_clk,
   input  wire        reset,
   input  wire        platRstN,
   input  wire        shutdownEvt,
   input  wire        failureMode,
   input  wire        lpcCycleStb,
   input  wire        lpcRead,
   input  wire        lpcAbortReq,
   input  wire        lpcAbortSyncEn,
   input  wire [7:0]  lpcWrData,
   input  wire [7:0]  lpcRdDataIn,
   output reg         lpcSyncValid,
   output reg  [7:0]  lpcRdData,
   output reg         lpcWrStb,
   output reg  [7:0]  lpcWrDataOut,
   input  wire        spiSclk,
   input  wire        spiCsN,
   input  wire        spiMosi,
   input  wire        spiDecoding,
   input  wire        spiAbortReq,
   input  wire        coreMisoBit,
   output reg         spiMiso,
   output reg         spiMisoOe,
   output reg  [7:0]  spiByte,
   output reg         spiByteStb,
   input  wire        hashStartWr,
   input  wire        hashDataWr,
   input  wire        hashEndWr,
   output reg         hashWrAck,
   output reg         hashSeqStart,
   output reg         hashSeqData,
   output reg         hashSeqEnd,
   input  wire        fifoRegStb,
   input  wire        crbRegStb,
   input  wire        locChgStb,
   output reg         fifoRegOut,
   output reg         crbRegOut,
   output reg         locChgOut,
   input  wire        execCmdWr,
   input  wire        crbStartWr,
   input  wire [1:0]  cmdClass,
   input  wire        selfTestActive,
   input  wire        cmdDone,
   output reg         respAvailFlag,
   output reg         statusValidFlag,
   output reg         crbStartBit,
   output reg         cmdBusy,
   output reg         durationOverrun,
   output reg         timeoutOverrun,
   output reg  [11:0] timeoutA,
   output reg  [11:0] timeoutB,
   output reg  [11:0] timeoutC,
   output reg  [11:0] timeoutD,
   output reg         initPulse,
   output reg         shutdownActive
);
   localparam [31:0] MS_LAST32 = MS_CYCLES - 1;

   reg        rstS1_q, rstS2_q, rstS3_q;
   reg        sclkS1_q, sclkS2_q, sclkS3_q;
   reg        csS1_q, csS2_q;
   reg        mosiS1_q, mosiS2_q;
   reg [1:0]  spiSt_q, spiSt_d;
   reg [2:0]  bitCnt_q;
   reg [7:0]  shift_q;
   reg [15:0] pre_q;
   reg [11:0] msCnt_q;
   reg [11:0] durLim, tmoLim;
   wire       clr, sclkRise, sclkFall, csActive, msTick, lpcAbort, spiAbort, anyGo;

   // Pins are synchronised twice before any logic looks at them.
   always @(posedge core_clk) begin
      rstS1_q  <= platRstN;
      rstS2_q  <= rstS1_q;
      rstS3_q  <= rstS2_q;
      sclkS1_q <= spiSclk;
      sclkS2_q <= sclkS1_q;
      sclkS3_q <= sclkS2_q;
      csS1_q   <= spiCsN;
      csS2_q   <= csS1_q;
      mosiS1_q <= spiMosi;
      mosiS2_q <= mosiS1_q;
   end

   assign sclkRise = sclkS2_q & ~sclkS3_q;
   assign sclkFall = ~sclkS2_q & sclkS3_q;
   assign csActive = ~csS2_q;

   // Reinitialise on the low-to-high edge of the platform reset pin.
   always @(posedge core_clk) begin
      if (reset) begin
         initPulse <= 1'b0;
      end else begin
         initPulse <= rstS2_q & ~rstS3_q; // see R22
      end
   end
   assign clr = reset | initPulse; // see R22

   // Shutdown sticks until a reset; a new event in the init cycle still wins.
   always @(posedge core_clk) begin
      if (reset) begin
         shutdownActive <= 1'b0;
      end else if (shutdownEvt) begin
         shutdownActive <= 1'b1; // see R21
      end else if (initPulse) begin
         shutdownActive <= 1'b0;
      end
   end

   assign lpcAbort = lpcAbortReq | shutdownActive; // see R21
   assign spiAbort = spiAbortReq | shutdownActive; // see R21

   // LPC: an aborted cycle never reaches the internal write strobe.
   always @(posedge core_clk) begin
      if (clr) begin
         lpcSyncValid <= 1'b0;
         lpcRdData    <= `SMA_BYTE_ZERO;
         lpcWrStb     <= 1'b0;
         lpcWrDataOut <= `SMA_BYTE_ZERO;
      end else begin
         lpcSyncValid <= lpcCycleStb & (~lpcAbort | lpcAbortSyncEn); // see R02
         lpcWrStb     <= lpcCycleStb & ~lpcRead & ~lpcAbort; // see R01
         if (lpcCycleStb & ~lpcRead & ~lpcAbort) begin
            lpcWrDataOut <= lpcWrData;
         end
         if (lpcCycleStb & lpcRead) begin
            lpcRdData <= lpcAbort ? `SMA_ALL_ONES : lpcRdDataIn; // see R02
         end
      end
   end

   // SPI transaction state; an abort holds until chip select is released.
   always @* begin
      spiSt_d = spiSt_q;
      case (spiSt_q)
         `SMA_SPI_IDLE: begin
            if (csActive) begin
               spiSt_d = spiAbort ? `SMA_SPI_ABORT : (spiDecoding ? `SMA_SPI_DECODE : `SMA_SPI_ACTIVE);
            end
         end
         `SMA_SPI_DECODE: begin
            if (!csActive) begin
               spiSt_d = `SMA_SPI_IDLE;
            end else if (spiAbort) begin
               spiSt_d = `SMA_SPI_ABORT; // see R05
            end else if (!spiDecoding) begin
               spiSt_d = `SMA_SPI_ACTIVE;
            end
         end
         `SMA_SPI_ACTIVE: begin
            if (!csActive) begin
               spiSt_d = `SMA_SPI_IDLE;
            end else if (spiAbort) begin
               spiSt_d = `SMA_SPI_ABORT;
            end else if (spiDecoding) begin
               spiSt_d = `SMA_SPI_DECODE;
            end
         end
         `SMA_SPI_ABORT: begin
            if (!csActive) begin
               spiSt_d = `SMA_SPI_IDLE; // see R03
            end
         end
         default: begin
            spiSt_d = `SMA_SPI_IDLE;
         end
      endcase
   end

   // MISO changes on the falling clock edge, but an abort shows at once.
   always @(posedge core_clk) begin
      if (clr) begin
         spiSt_q   <= `SMA_SPI_IDLE;
         spiMiso   <= 1'b0;
         spiMisoOe <= 1'b0;
      end else begin
         spiSt_q   <= spiSt_d;
         spiMisoOe <= csActive;
         if (spiSt_d == `SMA_SPI_ABORT) begin
            spiMiso <= 1'b1; // see R03, R04
         end else if (sclkFall) begin
            spiMiso <= (spiSt_d == `SMA_SPI_DECODE) ? 1'b0 : coreMisoBit; // see R05
         end
      end
   end

   // Bytes are assembled on rising edges and dropped once aborted.
   always @(posedge core_clk) begin
      if (clr) begin
         bitCnt_q   <= `SMA_BIT_ZERO;
         shift_q    <= `SMA_BYTE_ZERO;
         spiByte    <= `SMA_BYTE_ZERO;
         spiByteStb <= 1'b0;
      end else begin
         spiByteStb <= 1'b0;
         if (!csActive) begin
            bitCnt_q <= `SMA_BIT_ZERO;
         end else if (sclkRise) begin
            shift_q  <= {shift_q[6:0], mosiS2_q};
            bitCnt_q <= bitCnt_q + `SMA_BIT_ONE;
            if (bitCnt_q == `SMA_BIT_LAST && spiSt_d != `SMA_SPI_ABORT) begin
               spiByte    <= {shift_q[6:0], mosiS2_q};
               spiByteStb <= 1'b1; // see R04
            end
         end
      end
   end

   // Hash writes complete on the bus unless shut down, but only act outside failure mode.
   always @(posedge core_clk) begin
      if (clr) begin
         hashWrAck    <= 1'b0;
         hashSeqStart <= 1'b0;
         hashSeqData  <= 1'b0;
         hashSeqEnd   <= 1'b0;
      end else begin
         hashWrAck    <= (hashStartWr | hashDataWr | hashEndWr) & ~shutdownActive; // see R06
         hashSeqStart <= hashStartWr & ~failureMode & ~shutdownActive; // see R07
         hashSeqData  <= hashDataWr & ~failureMode & ~shutdownActive; // see R07
         hashSeqEnd   <= hashEndWr & ~failureMode & ~shutdownActive; // see R07
      end
   end

   // Register and locality traffic ignores failure mode on purpose.
   always @(posedge core_clk) begin
      if (clr) begin
         fifoRegOut <= 1'b0;
         crbRegOut  <= 1'b0;
         locChgOut  <= 1'b0;
      end else begin
         fifoRegOut <= fifoRegStb & ~shutdownActive; // see R08
         crbRegOut  <= crbRegStb & ~shutdownActive; // see R09
         locChgOut  <= locChgStb & ~shutdownActive; // see R08, R09
      end
   end

   // Completion flags; a start in the completion cycle wins over the completion.
   assign anyGo = execCmdWr | crbStartWr;
   always @(posedge core_clk) begin
      if (clr) begin
         respAvailFlag   <= 1'b0;
         statusValidFlag <= 1'b0;
         crbStartBit     <= 1'b0;
         cmdBusy         <= 1'b0;
      end else begin
         if (execCmdWr) begin
            respAvailFlag   <= 1'b0;
            statusValidFlag <= 1'b0;
         end else if (cmdDone & cmdBusy) begin
            respAvailFlag   <= 1'b1; // see R11
            statusValidFlag <= 1'b1; // see R11
         end
         if (crbStartWr) begin
            crbStartBit <= 1'b1;
         end else if (cmdDone) begin
            crbStartBit <= 1'b0; // see R12
         end
         if (anyGo) begin
            cmdBusy <= 1'b1; // see R10
         end else if (cmdDone) begin
            cmdBusy <= 1'b0; // see R10
         end
      end
   end

   // Limits per command class; the exempt class covers large-key checks and OS-time reads.
   always @* begin
      durLim = `SMA_MS_MAX;
      tmoLim = `SMA_MS_MAX;
      case (cmdClass)
         `SMA_CLS_SHORT: begin
            durLim = `SMA_SHORT_DUR; // see R13
            tmoLim = `SMA_SHORT_TMO; // see R13
         end
         `SMA_CLS_LONG: begin
            durLim = `SMA_LONG_DUR; // see R14
            tmoLim = `SMA_LONG_TMO; // see R14
         end
         `SMA_CLS_FULL: begin
            durLim = `SMA_FULL_DUR; // see R14
            tmoLim = `SMA_FULL_TMO; // see R14
         end
         default: begin
            durLim = `SMA_MS_MAX; // see R15, R17
            tmoLim = `SMA_MS_MAX; // see R15, R17
         end
      endcase
   end

   // Millisecond prescaler; it freezes while an algorithm self-test runs.
   assign msTick = (pre_q == MS_LAST32[15:0]);
   always @(posedge core_clk) begin
      if (clr | anyGo) begin
         pre_q   <= `SMA_PRE_ZERO;
         msCnt_q <= `SMA_MS_ZERO;
      end else if (cmdBusy & ~selfTestActive) begin // see R16
         pre_q <= msTick ? `SMA_PRE_ZERO : pre_q + `SMA_PRE_ONE; // see R23
         if (msTick && msCnt_q != `SMA_MS_MAX) begin
            msCnt_q <= msCnt_q + `SMA_MS_ONE; // see R23
         end
      end
   end

   // Overrun flags stay up until the next command starts.
   always @(posedge core_clk) begin
      if (clr | anyGo) begin
         durationOverrun <= 1'b0;
         timeoutOverrun  <= 1'b0;
      end else if (cmdBusy && cmdClass != `SMA_CLS_EXEMPT) begin
         if (msCnt_q >= durLim) begin
            durationOverrun <= 1'b1; // see R13, R14
         end
         if (msCnt_q >= tmoLim) begin
            timeoutOverrun <= 1'b1; // see R13, R14
         end
      end
   end

   // The four interface timeout defaults, loaded at every init.
   always @(posedge core_clk) begin
      if (clr) begin
         timeoutA <= `SMA_TMO_A; // see R18
         timeoutB <= `SMA_TMO_B; // see R18, R20
         timeoutC <= `SMA_TMO_C; // see R19
         timeoutD <= `SMA_TMO_D; // see R19
      end
   end
endmodule // sma_abort_timing
`default_nettype wire

// File: src/sma_consts.vh
// Constants for the secure module abort and timing supervisor.
`ifndef SMA_CONSTS_VH
`define SMA_CONSTS_VH
`define SMA_CLK_HZ      32'd10000000
`define SMA_MS_PER_S    32'd1000
`define SMA_MS_CYCLES   (`SMA_CLK_HZ / `SMA_MS_PER_S)
`define SMA_PRE_ZERO    16'h0000
`define SMA_PRE_ONE     16'h0001
`define SMA_MS_ZERO     12'h000
`define SMA_MS_ONE      12'h001
`define SMA_MS_MAX      12'hfff
`define SMA_SHORT_DUR   12'h014
`define SMA_SHORT_TMO   12'h2ee
`define SMA_LONG_DUR    12'h2ee
`define SMA_LONG_TMO    12'h7d0
`define SMA_FULL_DUR    12'h3e8
`define SMA_FULL_TMO    12'h7d0
`define SMA_TMO_A       12'h2ee
`define SMA_TMO_B       12'h7d0
`define SMA_TMO_C       12'h0c8
`define SMA_TMO_D       12'h01e
`define SMA_CLS_SHORT   2'h0
`define SMA_CLS_LONG    2'h1
`define SMA_CLS_FULL    2'h2
`define SMA_CLS_EXEMPT  2'h3
`define SMA_ALL_ONES    8'hff
`define SMA_BYTE_ZERO   8'h00
`define SMA_BIT_ZERO    3'h0
`define SMA_BIT_ONE     3'h1
`define SMA_BIT_LAST    3'h7
`define SMA_SPI_IDLE    2'h0
`define SMA_SPI_DECODE  2'h1
`define SMA_SPI_ACTIVE  2'h2
`define SMA_SPI_ABORT   2'h3
`endif

// File: testbench/sma_abort_timing_assertions.sv
// Concurrent checks on the supervisor's ports.
`timescale 1ns/1ps
`default_nettype none
module sma_abort_timing_chk (
   input wire logic        core_clk,
   input wire logic        reset,
   input wire logic        failureMode,
   input wire logic        lpcCycleStb,
   input wire logic        lpcRead,
   input wire logic        lpcAbortReq,
   input wire logic        lpcAbortSyncEn,
   input wire logic        lpcSyncValid,
   input wire logic [7:0]  lpcRdData,
   input wire logic        lpcWrStb,
   input wire logic        spiCsN,
   input wire logic        spiAbortReq,
   input wire logic        spiMiso,
   input wire logic        hashStartWr,
   input wire logic        hashWrAck,
   input wire logic        hashSeqStart,
   input wire logic        execCmdWr,
   input wire logic        crbStartWr,
   input wire logic        cmdDone,
   input wire logic        respAvailFlag,
   input wire logic        statusValidFlag,
   input wire logic        crbStartBit,
   input wire logic        cmdBusy,
   input wire logic [11:0] timeoutA,
   input wire logic [11:0] timeoutB,
   input wire logic [11:0] timeoutC,
   input wire logic [11:0] timeoutD,
   input wire logic        shutdownActive
);
   default clocking dc @(posedge core_clk); endclocking
   default disable iff (reset);
   lpc_drop_a: assert property ((lpcAbortReq || shutdownActive) && lpcCycleStb |=> !lpcWrStb)
      else $error("aborted cycle wrote");
   lpc_ones_a: assert property (lpcCycleStb && lpcRead && lpcAbortReq && lpcAbortSyncEn
      |=> lpcSyncValid && lpcRdData == 8'hff) else $error("abort read not all ones");
   // CS must have been low long enough for the synchroniser to see it.
   spi_abort_a: assert property ($past(spiAbortReq, 2) && !spiCsN && $past(!spiCsN, 8) |-> spiMiso)
      else $error("abort miso low");
   hash_ack_a: assert property (hashStartWr && !shutdownActive |=> hashWrAck)
      else $error("hash write not acked");
   hash_gate_a: assert property (failureMode && hashStartWr |=> !hashSeqStart)
      else $error("hash started in failure");
   cmd_start_a: assert property (execCmdWr |=> cmdBusy && !respAvailFlag && !statusValidFlag)
      else $error("start not taken");
   fifo_done_a: assert property (cmdBusy && cmdDone && !execCmdWr && !crbStartWr
      |=> respAvailFlag && statusValidFlag && !cmdBusy) else $error("fifo flags not set");
   crb_done_a: assert property (crbStartBit && cmdDone && !crbStartWr |=> $fell(crbStartBit))
      else $error("start bit not cleared");
   tmo_dflt_a: assert property (timeoutA == 12'h2ee && timeoutB == 12'h7d0
      && timeoutC == 12'h0c8 && timeoutD == 12'h01e) else $error("timeout default");
   cover property (lpcCycleStb && lpcAbortReq && lpcRead);
   cover property (failureMode && hashStartWr);
   cover property (cmdBusy && cmdDone);
endmodule // sma_abort_timing_chk
`default_nettype wire

// File: testbench/sma_host_model.sv
// Behavioural SPI controller standing in for the host chipset.
`timescale 1ns/1ps
`default_nettype none
module sma_host_model (
   output logic      spiSclk,
   output logic      spiCsN,
   output logic      spiMosi,
   input wire logic  spiMiso
);
   logic [15:0] rxBits;
   initial {spiSclk, spiCsN, spiMosi} = 3'h2;
   // Mode 0 at 800 ns a bit; the clock stands still between frames.
   task automatic frame(input logic [15:0] tx);
      spiCsN = 1'h0;
      #800;
      for (int i = 15; i >= 0; i--) begin
         spiMosi = tx[i];
         #400 spiSclk = 1'h1;
         rxBits = {rxBits[14:0], spiMiso};
         #400 spiSclk = 1'h0;
      end
      #800 spiCsN = 1'h1;
      // Nobody holds data after the frame, so show the opposite level.
      spiMosi = ~spiMosi;
   endtask
endmodule // sma_host_model
`default_nettype wire

// File: testbench/tb.sv
// Self-checking bench for the abort and timing supervisor.
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic core_clk, reset, platRstN, shutdownEvt, failureMode, lpcCycleStb;
   logic lpcRead, lpcAbortReq, lpcAbortSyncEn, lpcSyncValid, lpcWrStb;
   logic [7:0] lpcWrData, lpcRdDataIn, lpcRdData, lpcWrDataOut, spiByte;
   logic spiDecoding, spiAbortReq, coreMisoBit, spiMiso, spiMisoOe, spiByteStb;
   logic hashStartWr, hashDataWr, hashEndWr, hashWrAck;
   logic hashSeqStart, hashSeqData, hashSeqEnd;
   logic fifoRegStb, crbRegStb, locChgStb, fifoRegOut, crbRegOut, locChgOut;
   logic execCmdWr, crbStartWr, selfTestActive, cmdDone, respAvailFlag;
   logic statusValidFlag, crbStartBit, cmdBusy, durationOverrun, timeoutOverrun;
   logic initPulse, shutdownActive;
   logic [11:0] timeoutA, timeoutB, timeoutC, timeoutD;
   logic [1:0] cmdClass;
   wire logic spiSclk, spiCsN, spiMosi;
   logic [31:0] r;
   logic [5:0] s;
   int fails, numChecks, nBytes;
   // Class, run time in ms, self-test held, duration and timeout overrun.
   int tab[6][5] = '{'{0, 25, 0, 1, 0}, '{0, 760, 0, 1, 1}, '{1, 800, 0, 1, 0},
                     '{2, 900, 0, 0, 0}, '{3, 800, 0, 0, 0}, '{0, 30, 1, 0, 0}};
   sma_abort_timing #(.MS_CYCLES(10)) dut (.*);
   sma_host_model host (.*);
   initial core_clk = 1'h0;
   always #50 core_clk = ~core_clk;
   always @(posedge core_clk) if (spiByteStb) nBytes++;
   task automatic tick;
      @(posedge core_clk);
      #10;
   endtask
   task automatic chk(input string n, input logic [15:0] e, g);
      numChecks++;
      if (g !== e) begin
         fails++;
         $display("MISMATCH %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic close_out;
      if (fails == 0 && numChecks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      {platRstN, reset} = 2'h3;
      {shutdownEvt, failureMode, lpcCycleStb, lpcRead, lpcAbortReq, lpcAbortSyncEn} = '0;
      {lpcWrData, lpcRdDataIn, spiDecoding, spiAbortReq, coreMisoBit} = '0;
      {hashStartWr, hashDataWr, hashEndWr, fifoRegStb, crbRegStb, locChgStb} = '0;
      {execCmdWr, crbStartWr, selfTestActive, cmdDone, cmdClass} = '0;
      r = $urandom(47);
      repeat (8) tick;
      reset = 1'h0;
      tick;
      // Back-to-back cycles; the first eight walk every abort code.
      for (int i = 0; i < 40; i++) begin
         r = $urandom;
         if (i < 8) r[2:0] = i[2:0];
         {lpcRead, lpcAbortReq, lpcAbortSyncEn} = r[2:0];
         {lpcWrData, lpcRdDataIn} = r[23:8];
         lpcCycleStb = 1'h1;
         tick;
         chk("sync", !r[1] | r[0], lpcSyncValid);
         chk("wstb", !r[1] & !r[2], lpcWrStb);
         if (!r[1] & !r[2]) chk("wdat", r[23:16], lpcWrDataOut);
         if (r[2] & (!r[1] | r[0])) chk("rdat", r[1] ? 8'hff : r[15:8], lpcRdData);
      end
      lpcCycleStb = 1'h0;
      for (int f = 0; f < 2; f++) begin
         failureMode = f[0];
         for (int i = 0; i < 6; i++) begin
            s = 6'h20 >> i;
            {hashStartWr, hashDataWr, hashEndWr, fifoRegStb, crbRegStb, locChgStb} = s;
            tick;
            chk("strb", {|s[5:3], f[0] ? 3'h0 : s[5:3], s[2:0]}, {hashWrAck, hashSeqStart,
               hashSeqData, hashSeqEnd, fifoRegOut, crbRegOut, locChgOut});
         end
         {hashStartWr, hashDataWr, hashEndWr, fifoRegStb, crbRegStb, locChgStb} = '0;
      end
      failureMode = 1'h0;
      foreach (tab[k]) begin
         cmdClass = tab[k][0][1:0];
         selfTestActive = tab[k][2][0];
         {execCmdWr, crbStartWr} = 2'h3;
         tick;
         {execCmdWr, crbStartWr} = 2'h0;
         chk("start", 3'h6, {cmdBusy, crbStartBit, respAvailFlag});
         repeat (tab[k][1] * 10) tick;
         cmdDone = 1'h1;
         tick;
         cmdDone = 1'h0;
         chk("done", {4'h3, tab[k][3][0], tab[k][4][0]}, {cmdBusy, crbStartBit,
            respAvailFlag, statusValidFlag, durationOverrun, timeoutOverrun});
      end
      selfTestActive = 1'h0;
      for (int a = 0; a < 2; a++) begin
         spiAbortReq = a[0];
         nBytes = 0;
         r = $urandom;
         host.frame(r[15:0]);
         repeat (6) tick;
         chk("nbyte", a ? 16'h0 : 16'h2, nBytes[15:0]);
         chk("miso", a ? 16'hffff : 16'h0, host.rxBits);
         if (!a) chk("byte", r[7:0], spiByte);
      end
      spiAbortReq = 1'h0;
      shutdownEvt = 1'h1;
      tick;
      shutdownEvt = 1'h0;
      {lpcCycleStb, lpcRead, lpcAbortReq, fifoRegStb} = 4'h9;
      tick;
      {lpcCycleStb, fifoRegStb} = 2'h0;
      chk("shut", 3'h4, {shutdownActive, lpcWrStb, fifoRegOut});
      platRstN = 1'h0;
      repeat (3) tick;
      platRstN = 1'h1;
      repeat (2) tick;
      chk("ipls", 1'h0, initPulse);
      tick;
      chk("ipls", 1'h1, initPulse);
      repeat (3) tick;
      chk("init", 1'h0, shutdownActive);
      chk("tmoa", 16'd750, {4'h0, timeoutA});
      chk("tmob", 16'd2000, {4'h0, timeoutB});
      chk("tmoc", 16'd200, {4'h0, timeoutC});
      chk("tmod", 16'd30, {4'h0, timeoutD});
      chk("misooe", 1'h0, spiMisoOe);
      close_out;
   end
   // The tests need about 3.5 ms; a hang is cut off well beyond that.
   initial begin
      #6000000;
      fails++;
      close_out;
   end
endmodule // tb
bind sma_abort_timing sma_abort_timing_chk sac (.*);
`default_nettype wire
